// [storm_ctl_pkg.sv]
/*
 * Constants for the global control register slice of a three-port switch:
 * register offsets, field positions, reset values and storm period timing.
 * Assumes a 125 MHz core clock and an 8-bit management register port.
 */
// Operation
// - Bit 5 enables switch MII flow control
// - Bit 4 selects 10 Mbps, else 100
// - Bit 3 replaces null VLAN ID, reset 0
// - Eleven-bit storm limit split over two registers
// - Storm period 67 ms at 100, 500 ms at 10
// - Storm limit resets to 0x063
// - Factory test registers reset 0x4e, 0x24, 0x24
// - Bit 6 enables PHY power save, reset 0
package storm_ctl_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam int         ADDR_W            = 8;
  localparam int         DATA_W            = 8;
  localparam int         LIMIT_W           = 11;
  localparam logic [7:0] ADDR_PORT_CTRL    = 8'h06;
  localparam logic [7:0] ADDR_STORM_LOW    = 8'h07;
  localparam logic [7:0] ADDR_FACTORY_A    = 8'h08;
  localparam logic [7:0] ADDR_FACTORY_B    = 8'h09;
  localparam logic [7:0] ADDR_FACTORY_C    = 8'h0a;
  localparam logic [7:0] ADDR_POWER_SAVE   = 8'h0b;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int         BIT_FLOW_CTL      = 5;
  localparam int         BIT_SPEED_10      = 4;
  localparam int         BIT_NULL_VID      = 3;
  localparam int         STORM_HI_MSB      = 2;
  localparam int         BIT_POWER_SAVE    = 6;
  localparam int         PS_LOW_MSB        = 5;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [2:0] STORM_HI_RST      = 3'h0;
  localparam logic [7:0] STORM_LOW_RST     = 8'h63;
  localparam logic [7:0] FACTORY_A_RST     = 8'h4e;
  localparam logic [7:0] FACTORY_B_RST     = 8'h24;
  localparam logic [7:0] FACTORY_C_RST     = 8'h24;
  localparam logic [5:0] PS_LOW_RST        = 6'h08;
  localparam logic [7:0] UNMAPPED_RD       = 8'h00;

  // ****************************************
  // Storm measurement period timing
  // ****************************************
  localparam int         CLK_KHZ           = 125000;
  localparam int         PERIOD_100_MS     = 67;
  localparam int         PERIOD_10_MS      = 500;
  localparam int         PERIOD_100_CYC    = PERIOD_100_MS * CLK_KHZ;
  localparam int         PERIOD_10_CYC     = PERIOD_10_MS * CLK_KHZ;

endpackage

// [storm_meter.sv]
/*
 * Per-port broadcast storm meter: counts accepted 64-byte blocks in one
 * measurement period and raises a block flag once the limit is reached.
 * Assumes a one-cycle period tick from the register slice.
 */
`timescale 1ns/1ps
module storm_meter
  import storm_ctl_pkg::*;
(
  input  wire logic               core_clk,
  input  wire logic               reset,
  input  wire logic               period_tick,
  input  wire logic               block_accept,
  input  wire logic [LIMIT_W-1:0] limit,
  output logic                    over_limit
);

  typedef struct packed {
    logic [LIMIT_W-1:0] count;
    logic               over;
  } meter_t;

  meter_t st_reg;
  meter_t st_next;

  // ****************************************
  // Counting
  // ****************************************
  // Count saturates so a long burst cannot wrap and reopen the port
  always_comb begin
    st_next = st_reg;
    if (period_tick) begin
      st_next.count = {{(LIMIT_W-1){1'b0}}, block_accept};
    end else if (block_accept && (st_reg.count != {LIMIT_W{1'b1}})) begin
      st_next.count = st_reg.count + {{(LIMIT_W-1){1'b0}}, 1'b1};
    end
    st_next.over = (st_next.count >= limit);
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign over_limit = st_reg.over;

  // ****************************************
  // Checks
  // ****************************************
  property p_meter_over;
    @(posedge core_clk) disable iff (reset)
      !$past(reset) |-> (over_limit == (st_reg.count >= $past(limit)));
  endproperty
  a_meter_over: assert property (p_meter_over) else $error("storm flag mismatch");

  property p_meter_clear;
    @(posedge core_clk) disable iff (reset)
      ($past(period_tick) && !$past(block_accept) && !$past(reset)) |-> st_reg.count == '0;
  endproperty
  a_meter_clear: assert property (p_meter_clear) else $error("count not cleared");

  c_meter_trip: cover property (@(posedge core_clk) disable iff (reset) $rose(over_limit));

endmodule

// [switch_global_control_regs.sv]
/*
 * Global control register slice 0x06 to 0x0b of a three-port switch:
 * MII flow control and speed straps, null VLAN ID replacement, broadcast
 * storm limit with its measurement period, factory test bytes and PHY
 * power save. Assumes a registered 8-bit management port synchronous to
 * core_clk and strap pins that are stable while reset is high.
 */
`timescale 1ns/1ps
module switch_global_control_regs
  import storm_ctl_pkg::*;
#(
  parameter int NUM_PORTS    = 3,
  parameter int PER_100_CYC  = PERIOD_100_CYC,
  parameter int PER_10_CYC   = PERIOD_10_CYC
)
(
  input  wire logic                 core_clk,
  input  wire logic                 reset,
  input  wire logic                 flow_ctl_strap_pin,
  input  wire logic                 speed_strap_pin,
  input  wire logic [ADDR_W-1:0]    reg_addr,
  input  wire logic                 reg_wr_en,
  input  wire logic [DATA_W-1:0]    reg_wr_data,
  input  wire logic                 reg_rd_en,
  input  wire logic [NUM_PORTS-1:0] block_accept,
  output logic      [DATA_W-1:0]    reg_rd_data,
  output logic                      flow_ctl_en,
  output logic                      speed_10m_sel,
  output logic                      null_vid_replace_en,
  output logic      [LIMIT_W-1:0]   storm_limit,
  output logic                      phy_power_save_en,
  output logic                      storm_period_tick,
  output logic      [NUM_PORTS-1:0] storm_block
);

  localparam int PER_W = $clog2(PER_10_CYC + 1);

  // ****************************************
  // Elaboration checks
  // ****************************************
  if (NUM_PORTS < 1) begin : g_bad_ports
    $error("NUM_PORTS must be at least 1");
  end
  if ((PER_100_CYC < 2) || (PER_10_CYC < PER_100_CYC)) begin : g_bad_period
    $error("storm periods must be at least 2 and ordered");
  end

  typedef struct packed {
    logic              flow_ctl;
    logic              speed_10;
    logic              null_vid;
    logic [2:0]        storm_hi;
    logic [7:0]        storm_lo;
    logic [7:0]        ft_a;
    logic [7:0]        ft_b;
    logic [7:0]        ft_c;
    logic              power_save;
    logic [5:0]        ps_low;
    logic [7:0]        rd_data;
    logic [PER_W-1:0]  period_cnt;
    logic              period_tick;
  } state_t;

  state_t           st_reg;
  state_t           st_next;
  logic [PER_W-1:0] period_last;

  function automatic logic [7:0] read_mux(input state_t s, input logic [7:0] addr);
    logic [7:0] v;
    v = UNMAPPED_RD;
    case (addr)
      ADDR_PORT_CTRL:  v = {2'b00, s.flow_ctl, s.speed_10, s.null_vid, s.storm_hi};
      ADDR_STORM_LOW:  v = s.storm_lo;
      ADDR_FACTORY_A:  v = s.ft_a;
      ADDR_FACTORY_B:  v = s.ft_b;
      ADDR_FACTORY_C:  v = s.ft_c;
      ADDR_POWER_SAVE: v = {1'b0, s.power_save, s.ps_low};
      default:         v = UNMAPPED_RD;
    endcase
    return v;
  endfunction

  // ****************************************
  // Next state
  // ****************************************
  // Period follows the live speed bit; a speed change takes effect mid period
  assign period_last = st_reg.speed_10 ? PER_W'(PER_10_CYC - 1) : PER_W'(PER_100_CYC - 1);

  always_comb begin
    st_next = st_reg;
    st_next.period_tick = (st_reg.period_cnt >= period_last);
    st_next.period_cnt  = st_next.period_tick ? '0 : st_reg.period_cnt + PER_W'(1);
    if (reg_wr_en) begin
      case (reg_addr)
        ADDR_PORT_CTRL: begin
          st_next.flow_ctl = reg_wr_data[BIT_FLOW_CTL];
          st_next.speed_10 = reg_wr_data[BIT_SPEED_10];
          st_next.null_vid = reg_wr_data[BIT_NULL_VID];
          st_next.storm_hi = reg_wr_data[STORM_HI_MSB:0];
        end
        ADDR_STORM_LOW: begin
          st_next.storm_lo = reg_wr_data;
        end
        // Factory bytes stay writable; software is expected to leave them alone
        ADDR_FACTORY_A: begin
          st_next.ft_a = reg_wr_data;
        end
        ADDR_FACTORY_B: begin
          st_next.ft_b = reg_wr_data;
        end
        ADDR_FACTORY_C: begin
          st_next.ft_c = reg_wr_data;
        end
        ADDR_POWER_SAVE: begin
          st_next.power_save = reg_wr_data[BIT_POWER_SAVE];
          st_next.ps_low     = reg_wr_data[PS_LOW_MSB:0];
        end
        default: begin
          st_next.rd_data = st_reg.rd_data;
        end
      endcase
    end
    // Read sees the value before a same-cycle write
    if (reg_rd_en) begin
      st_next.rd_data = read_mux(st_reg, reg_addr);
    end
  end

  // ****************************************
  // State register
  // ****************************************
  // Reset is synchronous, so straps are sampled on every clock edge while reset is high
  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_reg             <= '0;
      st_reg.flow_ctl    <= flow_ctl_strap_pin;
      st_reg.speed_10    <= speed_strap_pin;
      st_reg.null_vid    <= 1'b0;
      st_reg.storm_hi    <= STORM_HI_RST;
      st_reg.storm_lo    <= STORM_LOW_RST;
      st_reg.ft_a        <= FACTORY_A_RST;
      st_reg.ft_b        <= FACTORY_B_RST;
      st_reg.ft_c        <= FACTORY_C_RST;
      st_reg.power_save  <= 1'b0;
      st_reg.ps_low      <= PS_LOW_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rd_data         = st_reg.rd_data;
  assign flow_ctl_en         = st_reg.flow_ctl;
  assign speed_10m_sel       = st_reg.speed_10;
  assign null_vid_replace_en = st_reg.null_vid;
  assign storm_limit         = {st_reg.storm_hi, st_reg.storm_lo};
  assign phy_power_save_en   = st_reg.power_save;
  assign storm_period_tick   = st_reg.period_tick;

  // ****************************************
  // Per-port storm meters
  // ****************************************
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_meter
    storm_meter u_meter (
      .core_clk     (core_clk),
      .reset        (reset),
      .period_tick  (st_reg.period_tick),
      .block_accept (block_accept[p]),
      .limit        (storm_limit),
      .over_limit   (storm_block[p])
    );
  end

  // ****************************************
  // Checks
  // ****************************************
  property p_strap_flow;
    @(posedge core_clk) disable iff (reset)
      $fell(reset) |-> flow_ctl_en == $past(flow_ctl_strap_pin);
  endproperty
  a_strap_flow: assert property (p_strap_flow) else $error("flow strap lost");

  property p_strap_speed;
    @(posedge core_clk) disable iff (reset)
      $fell(reset) |-> speed_10m_sel == $past(speed_strap_pin);
  endproperty
  a_strap_speed: assert property (p_strap_speed) else $error("speed strap lost");

  property p_wr_flow;
    @(posedge core_clk) disable iff (reset)
      (reg_wr_en && reg_addr == ADDR_PORT_CTRL) |=>
        flow_ctl_en == $past(reg_wr_data[BIT_FLOW_CTL]);
  endproperty
  a_wr_flow: assert property (p_wr_flow) else $error("flow bit write lost");

  property p_reset_defaults;
    @(posedge core_clk) disable iff (reset)
      $fell(reset) |-> (!null_vid_replace_en && storm_limit == 11'h063 && !phy_power_save_en);
  endproperty
  a_reset_defaults: assert property (p_reset_defaults) else $error("bad reset default");

  property p_null_vid;
    @(posedge core_clk) disable iff (reset)
      (reg_wr_en && reg_addr == ADDR_PORT_CTRL) |=>
        null_vid_replace_en == $past(reg_wr_data[BIT_NULL_VID]);
  endproperty
  a_null_vid: assert property (p_null_vid) else $error("null vid bit wrong");

  property p_storm_split;
    @(posedge core_clk) disable iff (reset)
      (reg_rd_en && reg_addr == ADDR_PORT_CTRL) |=> reg_rd_data[2:0] == $past(storm_limit[10:8]);
  endproperty
  a_storm_split: assert property (p_storm_split) else $error("storm high bits misplaced");

  property p_factory;
    @(posedge core_clk) disable iff (reset)
      $fell(reset) |-> (st_reg.ft_a == 8'h4e && st_reg.ft_b == 8'h24 && st_reg.ft_c == 8'h24);
  endproperty
  a_factory: assert property (p_factory) else $error("factory default wrong");

  property p_power_save;
    @(posedge core_clk) disable iff (reset)
      (reg_wr_en && reg_addr == ADDR_POWER_SAVE) |=>
        phy_power_save_en == $past(reg_wr_data[BIT_POWER_SAVE]);
  endproperty
  a_power_save: assert property (p_power_save) else $error("power save write lost");

  // Tick exactly when the count has reached the end; a speed change can overshoot it
  property p_period;
    @(posedge core_clk) disable iff (reset)
      !$past(reset) |->
        (storm_period_tick == ($past(st_reg.period_cnt) >= $past(period_last)));
  endproperty
  a_period: assert property (p_period) else $error("period tick early");

  c_wr_ctrl: cover property (@(posedge core_clk) disable iff (reset)
    reg_wr_en && reg_addr == ADDR_PORT_CTRL);
  c_rd_low: cover property (@(posedge core_clk) disable iff (reset)
    reg_rd_en && reg_addr == ADDR_STORM_LOW);
  c_tick: cover property (@(posedge core_clk) disable iff (reset) storm_period_tick);

endmodule

// [tb_switch_global_control_regs.sv]
/*
 * Self-checking bench for the global control register slice: strap and
 * reset defaults, register access, storm limit, period and meter.
 * Assumes storm_ctl_pkg is compiled first; periods are shortened.
 */
`timescale 1ns/1ps
module tb_switch_global_control_regs
  import storm_ctl_pkg::*;
;
  // ****************************************
  // Signals
  // ****************************************
  localparam int P100 = 20;
  localparam int P10  = 50;
  logic       core_clk;
  logic       reset;
  logic       flow_ctl_strap_pin;
  logic       speed_strap_pin;
  logic [7:0] reg_addr;
  logic       reg_wr_en;
  logic [7:0] reg_wr_data;
  logic       reg_rd_en;
  logic [2:0] block_accept;
  logic [7:0] reg_rd_data;
  logic       flow_ctl_en;
  logic       speed_10m_sel;
  logic       null_vid_replace_en;
  logic [10:0] storm_limit;
  logic       phy_power_save_en;
  logic       storm_period_tick;
  logic [2:0] storm_block;
  int         mismatches;
  int         n_tests;

  switch_global_control_regs #(.NUM_PORTS(3), .PER_100_CYC(P100), .PER_10_CYC(P10)) u_dut (
    .core_clk(core_clk), .reset(reset), .flow_ctl_strap_pin(flow_ctl_strap_pin),
    .speed_strap_pin(speed_strap_pin), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .block_accept(block_accept),
    .reg_rd_data(reg_rd_data), .flow_ctl_en(flow_ctl_en), .speed_10m_sel(speed_10m_sel),
    .null_vid_replace_en(null_vid_replace_en), .storm_limit(storm_limit),
    .phy_power_save_en(phy_power_save_en), .storm_period_tick(storm_period_tick),
    .storm_block(storm_block));

  // ****************************************
  // Clock and tasks
  // ****************************************
  always #4 core_clk = ~core_clk;

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Strobe held one cycle; returns once the write is visible
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr_en   <= 1'b1;
    reg_addr    <= a;
    reg_wr_data <= d;
    @(posedge core_clk);
    reg_wr_en <= 1'b0;
    #1;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_rd_en <= 1'b1;
    reg_addr  <= a;
    @(posedge core_clk);
    reg_rd_en <= 1'b0;
    #1;
    chk({8'h00, reg_rd_data}, {8'h00, e});
  endtask

  // Counts edges up to the next tick; bounded
  task automatic wait_tick(output int n);
    for (n = 1; n <= 200; n++) begin
      @(posedge core_clk);
      if (storm_period_tick === 1'b1) begin
        return;
      end
    end
    mismatches++;
    close_out();
  endtask

  function automatic logic [15:0] outs();
    return {flow_ctl_en, speed_10m_sel, null_vid_replace_en, phy_power_save_en,
            1'b0, storm_limit};
  endfunction

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [7:0] addrs [7];
    logic [7:0] rsts [7];
    int n;
    addrs = '{8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c};
    rsts  = '{8'h00, 8'h63, 8'h4e, 8'h24, 8'h24, 8'h08, 8'h00};
    core_clk = 1'b0;
    reset = 1'b1;
    flow_ctl_strap_pin = 1'b0;
    speed_strap_pin = 1'b0;
    reg_addr = 8'h00;
    reg_wr_en = 1'b0;
    reg_wr_data = 8'h00;
    reg_rd_en = 1'b0;
    block_accept = 3'b000;
    mismatches = 0;
    n_tests = 0;
    repeat (20) @(posedge core_clk);
    reset <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      rd_chk(addrs[i], rsts[i]);
    end
    chk(outs(), 16'h0063);
    $display("test reset defaults done");

    // Pulled-up straps taken during reset, then overridden
    @(posedge core_clk);
    reset <= 1'b1;
    flow_ctl_strap_pin <= 1'b1;
    speed_strap_pin <= 1'b1;
    repeat (20) @(posedge core_clk);
    reset <= 1'b0;
    rd_chk(8'h06, 8'h30);
    chk(outs(), 16'hc063);
    wr(8'h06, 8'h00);
    chk(outs(), 16'h0063);
    $display("test straps done");

    wr(8'h06, 8'hff);
    chk(outs(), 16'he763);
    rd_chk(8'h06, 8'h3f);
    wr(8'h0b, 8'hff);
    chk({15'h0, phy_power_save_en}, 16'h0001);
    rd_chk(8'h0b, 8'h7f);
    wr(8'h0c, 8'h5a);
    rd_chk(8'h0c, 8'h00);
    wr(8'h08, 8'h11);
    rd_chk(8'h08, 8'h11);
    wr(8'h08, 8'h4e);
    wr(8'h0b, 8'h08);
    chk({15'h0, phy_power_save_en}, 16'h0000);
    wr(8'h06, 8'h05);
    wr(8'h07, 8'ha5);
    chk({5'h0, storm_limit}, 16'h05a5);
    rd_chk(8'h07, 8'ha5);
    $display("test register access done");

    // Limit of two blocks, 100 Mbps period
    wr(8'h06, 8'h00);
    wr(8'h07, 8'h02);
    wait_tick(n);
    wait_tick(n);
    chk(16'(n), 16'(P100));
    block_accept <= 3'b011;
    @(posedge core_clk);
    block_accept <= 3'b001;
    @(posedge core_clk);
    block_accept <= 3'b000;
    @(posedge core_clk);
    #1;
    chk({13'h0, storm_block}, 16'h0001);
    wait_tick(n);
    @(posedge core_clk);
    #1;
    chk({13'h0, storm_block}, 16'h0000);
    $display("test storm meter done");

    wr(8'h06, 8'h10);
    chk({15'h0, speed_10m_sel}, 16'h0001);
    wait_tick(n);
    wait_tick(n);
    chk(16'(n), 16'(P10));
    $display("test slow period done");
    close_out();
  end
endmodule
